// file: bpr_adc_model.sv
// Analog core stand-in: answers each column strobe with pixel codes
`timescale 1ns/100ps
`default_nettype none
module bpr_adc_model (
	input  wire logic            pclk,
	input  wire logic            col_stb,
	input  wire logic [11:0]     row_rd_addr,
	input  wire logic [9:0]      base,
	output logic      [3:0][9:0] pix_adc
);
	logic tog_q;
	initial tog_q = 1'b0;
	// Codes stand in the cycle after the strobe, when the datapath samples them
	// Churn values elsewhere so a late or early sample shows up as a mismatch
	// Dark rows give zero so the black estimate stays at zero
	always @(posedge pclk) begin
		tog_q <= ~tog_q;
		for (int p = 0; p < 4; p++) begin
			if (col_stb)
				pix_adc[p] <= (row_rd_addr < 12'h008) ? 10'h000 : base + 10'(p);
			else
				pix_adc[p] <= tog_q ? 10'h3ff : 10'h000;
		end
	end
endmodule : bpr_adc_model
`default_nettype wire

// file: bpr_pix_path.sv
// One pixel datapath: black level, digital gain, clamp and depth reduction
`timescale 1ns/100ps
`default_nettype none
module bpr_pix_path (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [9:0]       raw,
	input  wire logic             vld,
	input  wire logic [9:0]       black,
	input  wire logic [7:0]       dgain,
	input  wire logic [1:0]       comp,
	output logic      [9:0]       dat,
	output logic                  dat_vld
);
	import bpr_pkg::*;

	localparam logic [17:0] PMAX = 18'h003ff;

	typedef struct packed {
		logic       v;
		logic [9:0] d;
	} bpr_path_s;

	bpr_path_s   q, n;
	logic [9:0]  sub;
	logic [17:0] prod;
	logic [9:0]  cl;

	// Offset removal, gain, saturation, then optional bit depth reduction
	always_comb begin
		n    = q;
		sub  = (raw > black) ? raw - black : 10'h000;
		prod = ({8'h00, sub} * {10'h000, dgain}) >> DGAIN_SHIFT;
		cl   = (prod > PMAX) ? PMAX[9:0] : prod[9:0];
		n.v  = vld;
		case (comp)
			COMP_8:  n.d = cl >> SH_8;
			COMP_6:  n.d = cl >> SH_6;
			default: n.d = cl;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign dat     = q.d;
	assign dat_vld = q.v;

	// ****************************************
	// Checks
	// ****************************************
	comp_six_a: assert property (@(posedge pclk) disable iff (!presetn)
		vld && comp == COMP_6 |=> dat[9:6] == 4'h0)
		else $error("six bit mode leaks upper bits");
endmodule : bpr_pix_path
`default_nettype wire

// file: bpr_pkg.sv
// Shared constants, register map and types of the pixel array readout
package bpr_pkg;
	// ****************************************
	// Array geometry and datapath
	// ****************************************
	localparam int ACT_COLS  = 3264;
	localparam int ACT_ROWS  = 2448;
	localparam int PHY_COLS  = 3280;
	localparam int PHY_ROWS  = 2464;
	localparam int WIDE_ROWS = 1836;
	localparam int SCL_COLS  = 1920;
	localparam int SCL_ROWS  = 1080;
	localparam int BORDER    = (PHY_COLS - ACT_COLS) / 2;
	localparam int DARK_ROWS = 8;
	localparam int NPATH     = 4;
	localparam int PIX_W     = 10;
	localparam int AW        = 12;
	localparam int FPS_MAX   = 30;
	localparam int LANE_MBPS = 732;
	localparam int MAX_LANES = 4;
	localparam int CLK_NS    = 100;
	localparam int LINK_NS   = 800;
	localparam int LINK_CYC  = LINK_NS / CLK_NS;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_EXPO0 = 8'h04;
	localparam logic [7:0] OFS_EXPO1 = 8'h08;
	localparam logic [7:0] OFS_AGAIN = 8'h0c;
	localparam logic [7:0] OFS_AOFFS = 8'h10;
	localparam logic [7:0] OFS_DGAIN = 8'h14;
	localparam logic [7:0] OFS_STAT  = 8'h18;
	localparam logic [7:0] OFS_ROW   = 8'h1c;
	localparam int CTL_RUN = 0, CTL_MIRROR = 1, CTL_WIDE = 2, CTL_CTX = 3;
	localparam int CTL_LANE = 4, CTL_COMP = 6, CTL_FLASH = 8, CTL_TRIG = 9;
	localparam int CTL_SKIP = 10;
	localparam logic [11:0] CTRL_RST  = 12'h022;
	localparam logic [11:0] EXPO_RST  = 12'h010;
	localparam logic [7:0]  DGAIN_RST = 8'h40;
	localparam int DGAIN_SHIFT = 6;
	localparam int BLK_SHIFT   = 4;
	localparam int ST_FRM = 8, ST_BLK = 16;
	localparam logic [1:0] LANES_2 = 2'h0, LANES_3 = 2'h1;
	localparam logic [1:0] COMP_RAW = 2'h0, COMP_8 = 2'h1, COMP_6 = 2'h2;
	localparam int SH_8 = 2, SH_6 = 4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LINE  = 2'b01,
		ST_BLANK = 2'b11,
		ST_FEND  = 2'b10
	} bpr_state_e;
	typedef enum logic [1:0] {
		CL_RED = 2'b00, CL_GR = 2'b01, CL_GB = 2'b10, CL_BLUE = 2'b11
	} bpr_colour_e;
endpackage : bpr_pkg

// file: bpr_readout.sv
// Rolling row sequencer, register file and lane output of the pixel array
//
// Behaviour
// - Active 3264x2448 inside 3280x2464 bordered array
// - Reset a row, later read it, advance
// - Exposure is reset-to-read row interval
// - Read rows pass gain then 10-bit conversion
// - Digital chain applies corrections and digital gain
// - Shielded pixels drive black level offset
// - Even rows green/red, odd rows blue/green
// - Even columns red/green, odd blue/green
// - Mirror bit resets set: left to right
// - Analog gain and offset per colour
// - Output only on 2, 3 or 4 lanes
// - Settings in registers on host bus
// - Flash output follows exposure interval
// - Shutter output and trigger input
// - Four parallel pixel datapaths
// - Mirror, skipping, two register contexts
// - Full frames up to 30 per second
// - Widescreen window 3264x1836 unscaled
// - Reduced modes by decimating the window
// - Snapshot lanes at 732 Mbps each
// - Optional 10 to 8 or 6 bits
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module bpr_readout #(
	parameter int COLS   = bpr_pkg::ACT_COLS,
	parameter int ROWS   = bpr_pkg::ACT_ROWS,
	parameter int WROWS  = bpr_pkg::WIDE_ROWS,
	parameter int HBLANK = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [7:0]       paddr,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             link_clk,
	input  wire logic             trig_in,
	output logic      [11:0]      row_rst_addr,
	output logic                  row_rst_stb,
	output logic      [11:0]      row_rd_addr,
	output logic                  row_rd_stb,
	output logic      [11:0]      col_addr,
	output logic                  col_stb,
	output logic                  col_rev,
	output logic      [3:0][7:0]  ana_gain,
	output logic      [3:0][7:0]  ana_offs,
	input  wire logic [3:0][9:0]  pix_adc,
	output logic      [3:0][9:0]  lane_data,
	output logic      [3:0]       lane_vld,
	output logic                  frame_start,
	output logic                  line_start,
	output logic                  flash_out,
	output logic                  shutter_out
);
	import bpr_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	localparam longint NEED_BPS = longint'(ACT_COLS) * ACT_ROWS * PIX_W * FPS_MAX;
	localparam longint LINK_BPS = longint'(MAX_LANES) * LANE_MBPS * 1000000;
	generate
		if (COLS % (NPATH * 4) != 0 || COLS > ACT_COLS || ROWS >= 4096 ||
			WROWS > ROWS || HBLANK < 1 || HBLANK > 255) begin : g_bad
			$error("bpr_readout: unsupported geometry parameters");
		end
		if (NEED_BPS > LINK_BPS) begin : g_rate
			$error("bpr_readout: link cannot carry full frame rate");
		end
	endgenerate

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		bpr_state_e  st;
		logic [11:0] ctrl;
		logic [11:0] expo0;
		logic [11:0] expo1;
		logic [31:0] again;
		logic [31:0] aoffs;
		logic [7:0]  dgain;
		logic        wide;
		logic        mirror;
		logic [1:0]  skip;
		logic [11:0] expo;
		logic [12:0] slot;
		logic [11:0] grp;
		logic [7:0]  blk;
		logic        lk_p;
		logic        tr_p;
		logic [11:0] rst_addr;
		logic [11:0] rd_addr;
		logic [11:0] col_addr;
		logic        rst_stb;
		logic        rd_stb;
		logic        col_stb;
		logic        dark;
		logic        rd_act;
		logic        adc_v;
		logic [31:0] ag;
		logic [31:0] ao;
		logic [9:0]  black;
		logic [7:0]  frames;
		logic        expo_win;
		logic        fstart;
		logic        lstart;
		logic        first;
		logic        rem;
		logic [39:0] hold;
		logic [3:0]  lv;
		logic [39:0] ld;
		logic [31:0] rdata;
		logic        seen;
		logic [11:0] nrst;
		logic [11:0] nrd;
	} bpr_core_s;

	localparam bpr_core_s RST = '{st: ST_IDLE, ctrl: CTRL_RST, expo0: EXPO_RST,
		expo1: EXPO_RST, dgain: DGAIN_RST, mirror: 1'b1, default: '0};

	bpr_core_s        q, n;
	logic [1:0]       syn;
	logic             tick, trig_rise, setup, acc, hit, enter;
	logic [31:0]      rv;
	logic [11:0]      rows_n, win0, ngrp, base;
	logic [12:0]      ns, rk, ri, slot_end;
	logic             rst_ok, rd_ok, rdark;
	logic [11:0]      rda;
	logic [2:0]       nl;
	logic [1:0]       cl;
	logic signed [10:0] bdiff;
	logic [3:0][9:0]  pdat;
	logic [3:0]       pv;

	// Link clock and trigger are asynchronous pins
	bpr_sync #(.W(2)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({trig_in, link_clk}),
		.dout    (syn)
	);

	// ****************************************
	// Frame geometry from the latched settings
	// ****************************************
	assign rows_n   = AW'((q.wide ? WROWS : ROWS) >> q.skip);
	assign win0     = q.wide ? AW'((ROWS - WROWS) / 2) : '0;
	assign ngrp     = AW'((COLS / NPATH) >> q.skip);
	assign ns       = (q.st == ST_IDLE) ? '0 : q.slot + 13'h0001;
	assign rk       = ns - 13'(DARK_ROWS);
	assign ri       = ns - {1'b0, q.expo};
	assign slot_end = 13'(DARK_ROWS) + {1'b0, rows_n} + {1'b0, q.expo};
	// Resets cover the window; reads trail by the exposure count
	assign rst_ok   = ns >= 13'(DARK_ROWS) && rk < {1'b0, rows_n};
	assign rd_ok    = ns >= {1'b0, q.expo} && ri < 13'(DARK_ROWS) + {1'b0, rows_n};
	assign rdark    = ri < 13'(DARK_ROWS);
	assign rda      = rdark ? ri[11:0] :
		AW'(BORDER + win0 + ((ri[11:0] - AW'(DARK_ROWS)) << q.skip));
	assign base     = AW'((q.grp * AW'(NPATH)) << q.skip);
	assign nl       = (q.ctrl[CTL_LANE +: 2] == LANES_2) ? 3'h2 :
		(q.ctrl[CTL_LANE +: 2] == LANES_3) ? 3'h3 : 3'h4;
	assign bdiff    = $signed({1'b0, pix_adc[0]}) - $signed({1'b0, q.black});
	assign tick      = syn[0] & ~q.lk_p;
	assign trig_rise = syn[1] & ~q.tr_p;
	assign setup     = psel & ~penable;
	assign acc       = psel & penable;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n       = q;
		rv      = '0;
		hit     = 1'b1;
		enter   = 1'b0;
		cl      = '0;
		n.lk_p  = syn[0];
		n.tr_p  = syn[1];
		n.rst_stb = 1'b0;
		n.rd_stb  = 1'b0;
		n.col_stb = 1'b0;
		n.fstart  = 1'b0;
		n.lstart  = 1'b0;
		n.adc_v   = q.col_stb;
		n.lv      = '0;

		// Register read mux; data is registered in the setup cycle
		case (paddr)
			OFS_CTRL:  rv = {20'h0, q.ctrl};
			OFS_EXPO0: rv = {20'h0, q.expo0};
			OFS_EXPO1: rv = {20'h0, q.expo1};
			OFS_AGAIN: rv = q.again;
			OFS_AOFFS: rv = q.aoffs;
			OFS_DGAIN: rv = {24'h0, q.dgain};
			OFS_STAT:  rv = {6'h0, q.black, q.frames, 6'h0, q.expo_win, q.st != ST_IDLE};
			OFS_ROW:   rv = {20'h0, q.rd_addr};
			default: begin
				rv  = '0;
				hit = 1'b0;
			end
		endcase
		if (setup) begin
			n.rdata = rv;
		end
		// Writes land at the access edge; status words are read only
		if (acc && pwrite) begin
			case (paddr)
				OFS_CTRL: begin
					n.ctrl = pwdata[11:0];
					n.seen = 1'b1;
				end
				OFS_EXPO0: n.expo0 = pwdata[11:0];
				OFS_EXPO1: n.expo1 = pwdata[11:0];
				OFS_AGAIN: n.again = pwdata;
				OFS_AOFFS: n.aoffs = pwdata;
				OFS_DGAIN: n.dgain = pwdata[7:0];
				default: n.seen = q.seen;
			endcase
		end

		// Row sequencer, one step per rising link clock edge; ST_FEND steps on the next pclk
		case (q.st)
			ST_IDLE: begin
				// Window, mirror, skip and exposure settings are taken only between frames
				n.wide   = q.ctrl[CTL_WIDE];
				n.mirror = q.ctrl[CTL_MIRROR];
				n.skip   = (q.ctrl[CTL_SKIP +: 2] > 2'h2) ? 2'h2 : q.ctrl[CTL_SKIP +: 2];
				n.expo   = q.ctrl[CTL_CTX] ? q.expo1 : q.expo0;
				if (tick && q.ctrl[CTL_RUN] && (!q.ctrl[CTL_TRIG] || trig_rise)) begin
					n.st     = ST_LINE;
					n.fstart = 1'b1;
					enter    = 1'b1;
				end
			end
			ST_LINE: begin
				if (tick) begin
					if (q.rd_act) begin
						n.col_stb  = 1'b1;
						// Mirror set reads left to right
						n.col_addr = AW'(BORDER) + (q.mirror ? base :
							AW'(COLS - NPATH) - base);
					end
					n.grp = q.grp + 12'h001;
					if (q.grp == ngrp - 12'h001) begin
						n.st  = ST_BLANK;
						n.blk = 8'(HBLANK - 1);
					end
				end
			end
			ST_BLANK: begin
				if (tick) begin
					if (q.blk != 8'h00) begin
						n.blk = q.blk - 8'h01;
					end else if (ns == slot_end) begin
						n.st = ST_FEND;
					end else begin
						n.st  = ST_LINE;
						enter = 1'b1;
					end
				end
			end
			ST_FEND: begin
				// Next frame restarts at the first window row
				n.frames   = q.frames + 8'h01;
				n.expo_win = 1'b0;
				n.nrst     = '0;
				n.nrd      = '0;
				n.st       = ST_IDLE;
			end
			default: n.st = ST_IDLE;
		endcase

		// Row strobes at the start of each slot
		if (enter) begin
			n.slot     = ns;
			n.grp      = '0;
			n.rst_stb  = rst_ok;
			n.rst_addr = AW'(BORDER + win0 + (rk[11:0] << q.skip));
			n.rd_stb   = rd_ok;
			n.rd_act   = rd_ok;
			n.dark     = rdark;
			n.rd_addr  = rda;
			n.first    = rd_ok & ~rdark;
			if (rst_ok) begin
				n.nrst = q.nrst + 12'h001;
			end
			if (rd_ok && !rdark) begin
				n.nrd = q.nrd + 12'h001;
			end
			// Light sources fire from first reset to last read
			if (rst_ok && rk == '0) begin
				n.expo_win = 1'b1;
			end
			if (rd_ok && !rdark && ri - 13'(DARK_ROWS) == {1'b0, rows_n} - 13'h0001) begin
				n.expo_win = 1'b0;
			end
			// Analog gain and offset follow each path's colour
			for (int i = 0; i < NPATH; i++) begin
				cl = {rda[0], q.mirror ? i[0] : ~i[0]};
				n.ag[i*8 +: 8] = q.again[cl*8 +: 8];
				n.ao[i*8 +: 8] = q.aoffs[cl*8 +: 8];
			end
		end

		// Running average of shielded rows gives the offset
		if (q.adc_v && q.dark) begin
			n.black = q.black + 10'(bdiff >>> BLK_SHIFT);
		end

		// Spread each pixel group over the enabled lanes
		if (pv[0]) begin
			for (int i = 0; i < MAX_LANES; i++) begin
				n.lv[i]       = 3'(i) < nl;
				n.ld[i*10 +: 10] = pdat[i];
			end
			n.hold = pdat;
			n.rem  = nl < 3'h4;
			if (q.first) begin
				n.lstart = 1'b1;
				n.first  = 1'b0;
			end
		end else if (q.rem) begin
			for (int i = 0; i < MAX_LANES; i++) begin
				n.lv[i] = 3'(i) + nl < 3'h4;
				n.ld[i*10 +: 10] = (3'(i) + nl < 3'h4) ? q.hold[(3'(i) + nl)*10 +: 10] : '0;
			end
			n.rem = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	// ****************************************
	// Four pixel datapaths
	// ****************************************
	generate
		for (genvar g = 0; g < NPATH; g++) begin : g_path
			bpr_pix_path u_path (
				.pclk    (pclk),
				.presetn (presetn),
				.raw     (pix_adc[g]),
				.vld     (q.adc_v & ~q.dark),
				.black   (q.black),
				.dgain   (q.dgain),
				.comp    (q.ctrl[CTL_COMP +: 2]),
				.dat     (pdat[g]),
				.dat_vld (pv[g])
			);
		end
	endgenerate

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata       = q.rdata;
	assign pready       = 1'b1;
	assign pslverr      = acc & ~hit;
	assign row_rst_addr = q.rst_addr;
	assign row_rst_stb  = q.rst_stb;
	assign row_rd_addr  = q.rd_addr;
	assign row_rd_stb   = q.rd_stb;
	assign col_addr     = q.col_addr;
	assign col_stb      = q.col_stb;
	assign col_rev      = ~q.mirror;
	assign ana_gain     = q.ag;
	assign ana_offs     = q.ao;
	assign lane_data    = q.ld;
	assign lane_vld     = q.lv;
	assign frame_start  = q.fstart;
	assign line_start   = q.lstart;
	assign flash_out    = q.expo_win & q.ctrl[CTL_FLASH];
	assign shutter_out  = q.expo_win & q.ctrl[CTL_TRIG];

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	mirror_default_a: assert property (!q.seen |-> q.ctrl[CTL_MIRROR])
		else $error("mirror bit not set after reset");
	read_after_reset_a: assert property (row_rd_stb && !q.dark |-> q.nrd <= q.nrst)
		else $error("row read before its reset");
	expo_gap_a: assert property (row_rst_stb && q.slot == 13'(DARK_ROWS) |->
		q.nrd == '0)
		else $error("window row read before exposure");
	gain_colour_a: assert property (row_rd_stb && !q.dark && q.mirror |->
		ana_gain[0] == q.again[{row_rd_addr[0], 1'b0}*8 +: 8])
		else $error("analog gain not matched to colour");
	lane_limit_a: assert property (q.ctrl[CTL_LANE +: 2] == LANES_2 && $stable(q.ctrl) |->
		!lane_vld[2] && !lane_vld[3])
		else $error("disabled lane carries data");
	flash_gate_a: assert property (flash_out |-> q.ctrl[CTL_FLASH] && q.st != ST_IDLE)
		else $error("flash outside exposure");
	pix_latency_a: assert property (col_stb && !q.dark |-> ##2 pv[0] ##0 pv[3])
		else $error("pixel group lost in datapath");
	frame_count_a: assert property (q.st == ST_FEND |=> q.st == ST_IDLE
		##0 q.frames == $past(q.frames) + 8'h01)
		else $error("frame end not counted");
	black_src_a: assert property (q.black != $past(q.black) |-> $past(q.adc_v && q.dark))
		else $error("black level moved without dark data");
	apb_error_a: assert property (acc && !hit |-> pslverr ##0 prdata == '0)
		else $error("unmapped access not refused");

	frame_done_c: cover property (q.st == ST_FEND);
	trig_start_c: cover property (q.st == ST_IDLE && q.ctrl[CTL_TRIG] ##1 frame_start);
	second_beat_c: cover property (q.rem ##1 lane_vld[0]);
	dark_read_c: cover property (row_rd_stb && q.dark);
endmodule : bpr_readout
`default_nettype wire

// file: bpr_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none
module bpr_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	import bpr_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} bpr_sync_s;

	bpr_sync_s q, n;

	// First stage feeds only the second
	always_comb begin
		n      = q;
		n.meta = din;
		n.stab = q.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign dout = q.stab;
endmodule : bpr_sync
`default_nettype wire

// file: testbench.sv
// Self-checking bench: register bus, frame readout and lane packing
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import bpr_pkg::*;
	localparam int COLS = 64, ROWS = 16;
	typedef struct {
		logic [3:0]      v;
		logic [3:0][9:0] d;
	} bpr_note_s;
	logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic            link_clk, trig_in, rst_stb, rd_stb, col_stb, col_rev;
	logic            f_st, l_st, flash, shut, err;
	logic [7:0]      paddr, dg;
	logic [31:0]     pwdata, prdata, again, aoffs, rd;
	logic [11:0]     rst_a, rd_a, col_a;
	logic [3:0][7:0] gain, offs;
	logic [3:0][9:0] adc, ldat, w;
	logic [3:0]      lvld;
	logic [9:0]      base, nb;
	bpr_note_s       notes[$];
	bpr_note_s       nt;
	int              n_mismatch, total_checks, n_line, n_frame, seed, k, ix;
	bit              seen[4096];
	bit              flash_seen;

	bpr_readout #(.COLS(COLS), .ROWS(ROWS), .WROWS(12), .HBLANK(1)) bpr_readout_inst (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_clk(link_clk), .trig_in(trig_in),
		.row_rst_addr(rst_a), .row_rst_stb(rst_stb), .row_rd_addr(rd_a),
		.row_rd_stb(rd_stb), .col_addr(col_a), .col_stb(col_stb), .col_rev(col_rev),
		.ana_gain(gain), .ana_offs(offs), .pix_adc(adc), .lane_data(ldat),
		.lane_vld(lvld), .frame_start(f_st), .line_start(l_st), .flash_out(flash),
		.shutter_out(shut));
	bpr_adc_model bpr_adc_model_inst (.pclk(pclk), .col_stb(col_stb),
		.row_rd_addr(rd_a), .base(base), .pix_adc(adc));

	// ****************************************
	// Clocks and shared tasks
	// ****************************************
	always #50 pclk = ~pclk;
	initial begin
		link_clk = 1'b0;
		#137;
		forever #400 link_clk = ~link_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// Request held until the edge that samples pready high
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [9:0] pix(input int a, input int g, input int c);
		int v;
		v = (a * g) >> 6;
		if (v > 1023) v = 1023;
		return 10'(v >> (c == 1 ? 2 : c == 2 ? 4 : 0));
	endfunction : pix
	task automatic put(input logic [3:0] v, input logic [3:0][9:0] d);
		nt.v = v;
		nt.d = d;
		notes.push_back(nt);
	endtask : put

	// ****************************************
	// Output monitor
	// ****************************************
	always @(posedge pclk) begin
		if (presetn && lvld !== 4'h0) begin
			if (notes.size() == 0) chk("extra beat", 0, 1);
			else begin
				nt = notes.pop_front();
				chk("lane_vld", nt.v, lvld);
				for (int i = 0; i < 4; i++) if (nt.v[i]) chk("lane_data", nt.d[i], ldat[i]);
			end
		end
		if (col_stb && rd_a >= 12'h008) begin
			for (int p = 0; p < 4; p++) begin
				ix = 8 * {rd_a[0], col_a[0] ^ p[0]};
				chk("ana_gain", again[ix +: 8], gain[p]);
				chk("ana_offs", aoffs[ix +: 8], offs[p]);
			end
		end
		if (rst_stb) seen[rst_a] = 1'b1;
		// Each read uses up its reset, so every frame needs fresh resets
		if (rd_stb && rd_a >= 12'h008) begin
			chk("reset before read", 1, seen[rd_a]);
			seen[rd_a] = 1'b0;
		end
		if (l_st) n_line++;
		if (f_st) n_frame++;
		if (flash) flash_seen = 1'b1;
		if (shut !== 1'b0) chk("shutter_out", 0, shut);
	end
	initial begin
		#(60000 * 100);
		n_mismatch++;
		give_verdict();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'h69c6;
		{pclk, presetn, psel, penable, pwrite, trig_in} = '0;
		{paddr, pwdata, base} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("col_rev", 0, col_rev);
		apb(OFS_CTRL, 0, 0);
		chk("ctrl", 32'h022, rd);
		apb(OFS_EXPO0, 0, 0);
		chk("expo0", 32'h010, rd);
		apb(OFS_DGAIN, 0, 0);
		chk("dgain", 32'h040, rd);
		apb(8'hfc, 1, 32'h1234);
		chk("pslverr", 1, err);
		apb(8'hfc, 0, 0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		apb(OFS_ROW, 1, 32'h5a5);
		apb(OFS_ROW, 0, 0);
		chk("row ro", 0, {rd[30:0], err});
		again = $random(seed);
		aoffs = $random(seed);
		dg = 8'($random(seed));
		apb(OFS_AGAIN, 1, again);
		apb(OFS_AOFFS, 1, aoffs);
		apb(OFS_DGAIN, 1, {24'h0, dg});
		apb(OFS_EXPO0, 1, 32'h002);
		apb(OFS_EXPO1, 1, again);
		apb(OFS_EXPO1, 0, 0);
		chk("expo1", {20'h0, again[11:0]}, rd);
		// Live lane and depth fields are switched during the dark rows
		for (int m = 0; m < 3; m++) begin
			// For m above 0, frame m has left idle; the m = 0 write starts frame 0; either way its settings land before any window row
			for (k = 0; k < 20000 && m > 0 && n_frame <= m; k++) @(posedge pclk);
			chk("frame wait", 1, k < 20000);
			nb = 10'($unsigned($random(seed)) % 1000);
			base <= nb;
			for (int p = 0; p < 4; p++) w[p] = pix(nb + p, dg, m);
			for (int g = 0; g < ROWS * COLS / 4; g++) begin
				if (m == 0) put(4'hf, w);
				else if (m == 1) put(4'h7, w);
				else put(4'h3, w);
				if (m == 1) put(4'h1, {30'h0, w[3]});
				if (m == 2) put(4'h3, {20'h0, w[3], w[2]});
			end
			apb(OFS_CTRL, 1, 32'h003 | ((2 - m) << 4) | (m << 6) | ((m == 0) << 8));
		end
		for (k = 0; k < 20000 && notes.size() > 0; k++) @(posedge pclk);
		chk("notes left", 0, notes.size());
		chk("line_start count", 3 * ROWS, n_line);
		chk("frame_start count", 3, n_frame);
		chk("flash seen", 1, flash_seen);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
